// [verilog/pmta_pkg.sv]
// Contract
// - four pointer actions: none, post-inc, post-dec, pre-inc
// - table read loads one byte into latch
// - memory written in two-byte blocks
// - even-address write copies latch into holding register
// - holding register hidden from software
// - odd-address write starts long write, latch high
// - long write halts core, applies buffered data
// - programming needs vpp, enable bit, odd address
// - enable clear: odd write is short write
// - enable bit cleared only by reset
// - long write ends by reset or interrupt
// - enabled source flag ends programming regardless
// - disabled source flag never ends programming
// - enabled source, flag clear: write continues
// - matching global enable off: resume next instruction
// - low source, low enable: low vector
// - high source, high enable: high vector
// - ending long write leaves flag untouched
// - program pointer is 22 bits wide
// - pointer actions change only low 21 bits
// - table byte latch is 8 bits
// - long-write enable is reset control bit 6
package pmta_pkg;

    // pointer and data widths
    localparam int PTR_W = 22;
    localparam int PTR_LOW_W = 21;
    localparam int BYTE_W = 8;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_POINTER = 8'h00;
    localparam logic [7:0] OFS_LATCH = 8'h04;
    localparam logic [7:0] OFS_RESET_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;

    // field positions
    localparam int LWE_BIT = 6;
    localparam int ST_PROG_BIT = 0;
    localparam int ST_VPP_BIT = 1;
    localparam int ST_ACT_LSB = 2;

    // reset values
    localparam logic [21:0] PTR_RST = 22'h000000;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // pointer action codes of a table operation
    typedef enum logic [1:0] {
        PMTA_PTR_KEEP = 2'h0,
        PMTA_PTR_POST_INC = 2'h1,
        PMTA_PTR_POST_DEC = 2'h2,
        PMTA_PTR_PRE_INC = 2'h3
    } pmta_ptr_act_type;

    // how the core resumes after a long write ends
    typedef enum logic [1:0] {
        PMTA_RES_NEXT = 2'h0,
        PMTA_RES_LOW_VEC = 2'h1,
        PMTA_RES_HIGH_VEC = 2'h2
    } pmta_resume_type;

    // write engine states, gray along idle -> prog -> done; done -> idle flips both bits
    typedef enum logic [1:0] {
        PMTA_IDLE = 2'b00,
        PMTA_PROG = 2'b01,
        PMTA_DONE = 2'b11
    } pmta_state_type;

endpackage

// [verilog/pmta_top.sv]
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module pmta_top #(
    parameter int MEM_AW = 10 // program memory byte address width
) (
    input wire logic clk_i, // 250 MHz core clock
    input wire logic nrst_i, // power-on / master-clear reset
    input wire logic hsel_i, // ahb select
    input wire logic [31:0] haddr_i, // ahb address
    input wire logic [1:0] htrans_i, // ahb transfer type
    input wire logic hwrite_i, // ahb write
    input wire logic [2:0] hsize_i, // ahb size, word only
    input wire logic [31:0] hwdata_i, // ahb write data
    input wire logic hready_i, // ahb bus ready
    output logic hreadyout_o, // ahb slave ready
    output logic hresp_o, // ahb response, always okay
    output logic [31:0] hrdata_o, // ahb read data
    input wire logic op_valid_i, // core issues a table op this cycle
    input wire logic op_write_i, // 1 table_write_op, 0 table_read_op
    input wire pmta_pkg::pmta_ptr_act_type op_act_i, // pointer action
    input wire logic master_clear_program_pin_i, // vpp level present, async pin
    input wire logic src_irq_enable_i, // terminating source enable
    input wire logic src_irq_flag_i, // terminating source flag
    input wire logic src_irq_high_prio_i, // source priority, 1 high
    input wire logic global_high_irq_enable_i, // high / global enable
    input wire logic peripheral_low_irq_enable_i, // low / peripheral enable
    output logic core_halt_o, // core must stall
    output logic resume_valid_o, // one-cycle pulse, long write ended
    output pmta_pkg::pmta_resume_type resume_act_o, // resume target
    output logic [7:0] table_byte_latch_o, // latch contents
    output logic [21:0] program_pointer_o // pointer contents
);
    import pmta_pkg::*;

    typedef struct packed {
        logic [PTR_W-1:0] ptr;
        logic [BYTE_W-1:0] latch;
        logic [BYTE_W-1:0] hold;
        logic lwe;
        logic vpp_meta;
        logic vpp;
        pmta_state_type state;
        logic halt;
        logic resume_valid;
        pmta_resume_type resume_act;
        pmta_resume_type last_act;
        logic wr_pend;
        logic [7:0] wr_ofs;
        logic [31:0] rdata;
        logic readyout;
    } pmta_regs_type;

    pmta_regs_type cur_r;
    pmta_regs_type cur_nxt;

    // program memory, one byte per entry
    logic [BYTE_W-1:0] mem_r [2**MEM_AW];
    logic mem_we;
    logic [MEM_AW-1:0] mem_idx;
    logic [BYTE_W-1:0] mem_lo;
    logic [BYTE_W-1:0] mem_hi;

    // helper views
    logic [PTR_W-1:0] eff_addr;
    logic [BYTE_W-1:0] rd_byte;
    logic op_ok;
    logic bus_take;
    logic term_hit;
    pmta_resume_type term_act;

    // step the low pointer bits with wrap, bit 21 left alone
    function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic up);
        logic [PTR_LOW_W-1:0] low;
        low = up ? PTR_LOW_W'(p[PTR_LOW_W-1:0] + 1'b1) : PTR_LOW_W'(p[PTR_LOW_W-1:0] - 1'b1);
        return {p[PTR_W-1], low};
    endfunction

    // ops are only taken while the engine is idle; ops offered while halted are dropped
    assign op_ok = op_valid_i && (cur_r.state == PMTA_IDLE);
    assign bus_take = hsel_i && htrans_i[1] && hready_i;

    // address used by the access itself
    always_comb begin
        eff_addr = cur_r.ptr;
        if (op_act_i == PMTA_PTR_PRE_INC) begin
            eff_addr = ptr_step(cur_r.ptr, 1'b1);
        end
    end

    // configuration space with bit 21 set is not modelled and reads as zero
    assign rd_byte = eff_addr[PTR_W-1] ? 8'h00 : mem_r[eff_addr[MEM_AW-1:0]];

    // termination: only the source's own enable and flag matter
    assign term_hit = src_irq_enable_i && src_irq_flag_i;

    // resume target from priority and the matching global enable
    always_comb begin
        term_act = PMTA_RES_NEXT;
        if (src_irq_high_prio_i && global_high_irq_enable_i) begin
            term_act = PMTA_RES_HIGH_VEC;
        end else if (!src_irq_high_prio_i && peripheral_low_irq_enable_i) begin
            term_act = PMTA_RES_LOW_VEC;
        end
    end

    // all next-state logic
    always_comb begin
        cur_nxt = cur_r;
        mem_we = 1'b0;
        mem_idx = eff_addr[MEM_AW-1:0];
        mem_lo = cur_r.hold;
        mem_hi = cur_r.latch;
        cur_nxt.resume_valid = 1'b0;
        cur_nxt.readyout = 1'b1;
        // vpp pin through two flops, first only feeds the second
        cur_nxt.vpp_meta = master_clear_program_pin_i;
        cur_nxt.vpp = cur_r.vpp_meta;

        // bus data phase of a write; core ops below win on a clash
        if (cur_r.wr_pend) begin
            unique case (cur_r.wr_ofs)
                OFS_POINTER: cur_nxt.ptr = hwdata_i[PTR_W-1:0];
                OFS_LATCH: cur_nxt.latch = hwdata_i[BYTE_W-1:0];
                OFS_RESET_CTRL: begin
                    // writing zero never clears it
                    if (hwdata_i[LWE_BIT]) begin
                        cur_nxt.lwe = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // bus address phase: capture writes, prepare read data
        cur_nxt.wr_pend = bus_take && hwrite_i;
        cur_nxt.wr_ofs = haddr_i[7:0];
        if (bus_take && !hwrite_i) begin
            unique case (haddr_i[7:0])
                OFS_POINTER: cur_nxt.rdata = {10'h000, cur_r.ptr};
                OFS_LATCH: cur_nxt.rdata = {24'h000000, cur_r.latch};
                OFS_RESET_CTRL: cur_nxt.rdata = {25'h0000000, cur_r.lwe, 6'h00};
                OFS_STATUS: cur_nxt.rdata = {28'h0000000, cur_r.last_act,
                    cur_r.vpp, cur_r.halt};
                default: cur_nxt.rdata = 32'h00000000;
            endcase
        end

        // write engine
        unique case (cur_r.state)
            PMTA_IDLE: begin
                if (op_ok) begin
                    // pointer action of the op
                    unique case (op_act_i)
                        PMTA_PTR_KEEP: cur_nxt.ptr = cur_r.ptr;
                        PMTA_PTR_POST_INC: cur_nxt.ptr = ptr_step(cur_r.ptr, 1'b1);
                        PMTA_PTR_POST_DEC: cur_nxt.ptr = ptr_step(cur_r.ptr, 1'b0);
                        PMTA_PTR_PRE_INC: cur_nxt.ptr = eff_addr;
                    endcase
                    if (!op_write_i) begin
                        cur_nxt.latch = rd_byte;
                    end else if (!eff_addr[0]) begin
                        // short write, memory untouched
                        cur_nxt.hold = cur_r.latch;
                    end else if (cur_r.vpp && cur_r.lwe && !eff_addr[PTR_W-1]) begin
                        // block applied as the long write starts
                        mem_we = 1'b1;
                        mem_idx = {eff_addr[MEM_AW-1:1], 1'b0};
                        cur_nxt.state = PMTA_PROG;
                        cur_nxt.halt = 1'b1;
                    end
                    // otherwise an odd write without the enable is a short write
                end
            end
            PMTA_PROG: begin
                // flag stays with its owner; nothing here clears it
                if (term_hit) begin
                    cur_nxt.state = PMTA_DONE;
                    cur_nxt.halt = 1'b0;
                    cur_nxt.resume_valid = 1'b1;
                    cur_nxt.resume_act = term_act;
                    cur_nxt.last_act = term_act;
                end
            end
            PMTA_DONE: begin
                // one spare cycle so the core sees the resume pulse before new ops
                cur_nxt.state = PMTA_IDLE;
            end
            default: begin
                cur_nxt.state = PMTA_IDLE;
                cur_nxt.halt = 1'b0;
            end
        endcase
    end

    // state register; reset is the only way to clear the enable bit
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur_r <= '{ptr: PTR_RST, latch: LATCH_RST, hold: LATCH_RST, lwe: 1'b0,
                vpp_meta: 1'b0, vpp: 1'b0, state: PMTA_IDLE, halt: 1'b0,
                resume_valid: 1'b0, resume_act: PMTA_RES_NEXT, last_act: PMTA_RES_NEXT,
                wr_pend: 1'b0, wr_ofs: 8'h00, rdata: 32'h00000000,
                readyout: 1'b1};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // memory array; reset leaves it erased so a bench starts from known data
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 2**MEM_AW; i++) begin
                mem_r[i] <= ERASED_BYTE;
            end
        end else if (mem_we) begin
            mem_r[mem_idx] <= mem_lo;
            mem_r[mem_idx | MEM_AW'(1)] <= mem_hi;
        end
    end

    // outputs straight from flops, except hresp_o tied to okay
    assign hreadyout_o = cur_r.readyout;
    assign hresp_o = 1'b0;
    assign hrdata_o = cur_r.rdata;
    assign core_halt_o = cur_r.halt;
    assign resume_valid_o = cur_r.resume_valid;
    assign resume_act_o = cur_r.resume_act;
    assign table_byte_latch_o = cur_r.latch;
    assign program_pointer_o = cur_r.ptr;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // op issue conditions
    sequence idle_op_s;
        op_valid_i && cur_r.state == PMTA_IDLE && !cur_r.wr_pend;
    endsequence
    sequence long_start_s;
        idle_op_s and (op_write_i && eff_addr[0] && !eff_addr[PTR_W-1]
            && cur_r.vpp && cur_r.lwe);
    endsequence
    sequence term_s;
        cur_r.state == PMTA_PROG && src_irq_enable_i && src_irq_flag_i;
    endsequence

    sequence prog_s;
        cur_r.state == PMTA_PROG;
    endsequence

    // keep action leaves the pointer alone
    ptr_keep_a: assert property (idle_op_s and op_act_i == PMTA_PTR_KEEP
        |=> $stable(cur_r.ptr)) else $error("pointer moved on keep action");

    // post decrement touches only the low bits
    ptr_dec_a: assert property (idle_op_s and op_act_i == PMTA_PTR_POST_DEC
        |=> cur_r.ptr[PTR_LOW_W-1:0] == PTR_LOW_W'($past(cur_r.ptr[PTR_LOW_W-1:0]) - 1'b1)
        && cur_r.ptr[PTR_W-1] == $past(cur_r.ptr[PTR_W-1]))
        else $error("post decrement wrong");

    // increment wraps without carrying into the top bit
    ptr_wrap_a: assert property (idle_op_s and op_act_i == PMTA_PTR_POST_INC
        and cur_r.ptr[PTR_LOW_W-1:0] == '1 |=> cur_r.ptr[PTR_LOW_W-1:0] == '0
        && $stable(cur_r.ptr[PTR_W-1])) else $error("pointer wrap carried");

    // a read lands the addressed byte in the latch
    read_latch_a: assert property (idle_op_s and !op_write_i
        |=> cur_r.latch == $past(rd_byte)) else $error("read byte not latched");

    // even write only fills the hidden register
    hold_even_a: assert property (idle_op_s and op_write_i && !eff_addr[0]
        |=> cur_r.hold == $past(cur_r.latch) && !cur_r.halt)
        else $error("even write did not fill holding register");

    // long write halts and stores the latch as the high byte
    long_start_a: assert property (long_start_s |=> cur_r.halt
        && mem_r[$past(eff_addr[MEM_AW-1:0])] == $past(cur_r.latch))
        else $error("long write did not start or store high byte");

    // enable bit clear: no long write
    no_long_a: assert property (idle_op_s and op_write_i && eff_addr[0] && !cur_r.lwe
        |=> !cur_r.halt) else $error("long write without enable");

    // only reset clears the enable bit
    lwe_sticky_a: assert property (cur_r.lwe |=> cur_r.lwe)
        else $error("long write enable cleared without reset");

    // a disabled source never ends programming
    no_term_a: assert property (cur_r.state == PMTA_PROG && !src_irq_enable_i
        |=> cur_r.halt) else $error("disabled source ended long write");

    // enabled source with its flag ends programming
    term_end_a: assert property (term_s |=> !cur_r.halt && cur_r.resume_valid
        ##1 !cur_r.resume_valid && cur_r.state == PMTA_IDLE)
        else $error("enabled flag did not end long write");

    // high source, high enable: high vector
    high_vec_a: assert property (term_s and src_irq_high_prio_i && global_high_irq_enable_i
        |=> cur_r.resume_act == PMTA_RES_HIGH_VEC) else $error("high vector not taken");

    // high source, high enable off: next instruction
    next_instr_a: assert property (term_s and src_irq_high_prio_i && !global_high_irq_enable_i
        |=> cur_r.resume_act == PMTA_RES_NEXT) else $error("vectored with enable off");

    // post increment moves the low bits up by one
    ptr_inc_a: assert property (idle_op_s and op_act_i == PMTA_PTR_POST_INC
        |=> cur_r.ptr[PTR_LOW_W-1:0] == PTR_LOW_W'($past(cur_r.ptr[PTR_LOW_W-1:0]) + 1'b1))
        else $error("post increment wrong");

    // pre increment leaves the pointer one up as well
    ptr_pre_a: assert property (idle_op_s and op_act_i == PMTA_PTR_PRE_INC
        |=> cur_r.ptr[PTR_LOW_W-1:0] == PTR_LOW_W'($past(cur_r.ptr[PTR_LOW_W-1:0]) + 1'b1))
        else $error("pre increment wrong");

    // pre increment uses the stepped address for the access
    pre_addr_a: assert property (idle_op_s and op_act_i == PMTA_PTR_PRE_INC
        |-> eff_addr[PTR_LOW_W-1:0] == PTR_LOW_W'(cur_r.ptr[PTR_LOW_W-1:0] + 1'b1))
        else $error("pre increment address wrong");

    // every other action accesses the current pointer
    post_addr_a: assert property (idle_op_s and op_act_i != PMTA_PTR_PRE_INC
        |-> eff_addr == cur_r.ptr) else $error("access address moved early");

    // no action ever changes the top pointer bit
    ptr_top_a: assert property (idle_op_s and op_act_i != PMTA_PTR_KEEP
        |=> $stable(cur_r.ptr[PTR_W-1])) else $error("pointer top bit changed");

    // decrement from zero wraps to all ones
    dec_wrap_a: assert property (idle_op_s and op_act_i == PMTA_PTR_POST_DEC
        and cur_r.ptr[PTR_LOW_W-1:0] == '0 |=> cur_r.ptr[PTR_LOW_W-1:0] == '1
        && $stable(cur_r.ptr[PTR_W-1])) else $error("pointer wrap borrowed");

    // top half of the pointer space is not modelled and reads zero
    cfg_read_a: assert property (idle_op_s and !op_write_i && eff_addr[PTR_W-1]
        |=> cur_r.latch == 8'h00) else $error("unmodelled space read nonzero");

    // odd write without the enable leaves the hidden register alone
    odd_short_a: assert property (idle_op_s and op_write_i && eff_addr[0] && !cur_r.lwe
        |=> $stable(cur_r.hold)) else $error("odd short write touched hold");

    // no programming voltage: no long write
    no_vpp_a: assert property (idle_op_s and op_write_i && eff_addr[0] && !cur_r.vpp
        |=> !cur_r.halt) else $error("long write without voltage");

    // hidden register becomes the low byte of the block
    mem_low_a: assert property (long_start_s
        |=> mem_r[{$past(eff_addr[MEM_AW-1:1]), 1'b0}] == $past(cur_r.hold))
        else $error("low byte not stored");

    // core stays halted for the whole programming state
    halt_prog_a: assert property (prog_s |-> cur_r.halt)
        else $error("programming without halt");

    // enabled source, flag still clear: keep programming
    cont_a: assert property (prog_s and src_irq_enable_i && !src_irq_flag_i
        |=> cur_r.halt) else $error("long write ended with flag clear");

    // low source, low enable: low vector
    low_vec_a: assert property (term_s and !src_irq_high_prio_i && peripheral_low_irq_enable_i
        |=> cur_r.resume_act == PMTA_RES_LOW_VEC) else $error("low vector not taken");

    // low source, low enable off: next instruction
    low_next_a: assert property (term_s and !src_irq_high_prio_i && !peripheral_low_irq_enable_i
        |=> cur_r.resume_act == PMTA_RES_NEXT) else $error("low source vectored");

    // ops offered while halted are dropped
    drop_op_a: assert property (cur_r.halt && op_valid_i && !cur_r.wr_pend
        |=> $stable(cur_r.latch)) else $error("op taken while halted");

    // writing one to the enable bit sets it
    lwe_set_a: assert property (cur_r.wr_pend && cur_r.wr_ofs == OFS_RESET_CTRL
        && hwdata_i[LWE_BIT] |=> cur_r.lwe) else $error("enable bit not set");

    // resume indication lasts a single cycle
    pulse_a: assert property (cur_r.resume_valid |=> !cur_r.resume_valid)
        else $error("resume pulse too long");

    // voltage level passes both flops in order
    vpp_sync_a: assert property (cur_r.vpp == $past(cur_r.vpp_meta))
        else $error("voltage synchroniser skipped a stage");

endmodule
`default_nettype wire

// [bench/pmta_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
// stands in for the instruction core and its terminating interrupt source
module pmta_core_model #(
    parameter int MIN_PROG = 8 // cycles the source flag is held alone, before the 4 cycles of the enable alone
) (
    input wire logic clk_i, // core clock
    input wire logic core_halt_i, // block stalls the core
    input wire logic resume_valid_i, // long write ended
    input wire pmta_pkg::pmta_resume_type resume_act_i, // resume target
    output logic op_valid_o, // table op strobe
    output logic op_write_o, // 1 write, 0 read
    output pmta_pkg::pmta_ptr_act_type op_act_o, // pointer action
    output logic irq_en_o, // source enable
    output logic irq_flag_o, // source flag
    output logic irq_high_o, // source priority
    output logic glh_o, // high / global enable
    output logic pl_o // low / peripheral enable
);
    import pmta_pkg::*;
    // idle core: no op, the one source disabled with its flag cleared
    initial begin
        {op_valid_o, op_write_o, irq_en_o, irq_flag_o, irq_high_o, glh_o, pl_o} = '0;
        op_act_o = PMTA_PTR_KEEP;
    end
    // one table instruction, strobe held for exactly one edge
    task automatic op(input logic wr, input pmta_ptr_act_type act);
        @(posedge clk_i);
        op_valid_o <= 1'b1;
        op_write_o <= wr;
        op_act_o <= act;
        @(posedge clk_i);
        op_valid_o <= 1'b0;
    endtask
    // ends a running long write; held reports that the stall lasted until the end
    task automatic end_write(input logic hi, input logic gh, input logic lo,
                             output logic held, output pmta_resume_type act);
        int n;
        held = 1'b1;
        @(posedge clk_i);
        irq_high_o <= hi;
        glh_o <= gh;
        pl_o <= lo;
        irq_flag_o <= 1'b1;
        // the flag alone, then the enable alone, must not end programming
        repeat (MIN_PROG) begin
            @(posedge clk_i);
            held = held & core_halt_i;
        end
        irq_flag_o <= 1'b0;
        irq_en_o <= 1'b1;
        repeat (4) begin
            @(posedge clk_i);
            held = held & core_halt_i;
        end
        irq_flag_o <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (resume_valid_i !== 1'b1 && n < 50);
        held = held & resume_valid_i;
        act = resume_act_i;
        // software clears the flag itself, the block leaves it alone
        irq_flag_o <= 1'b0;
        irq_en_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// [bench/program_memory_table_access_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module program_memory_table_access_tb_top;
    import pmta_pkg::*;
    logic clk_i, nrst_i, hsel, hwrite, vpp, held;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready, hresp, halt, rvalid, op_valid, op_write, ien, iflag, ihigh, glh, pl;
    wire logic [31:0] hrdata;
    wire pmta_ptr_act_type op_act;
    wire pmta_resume_type ract;
    wire logic [7:0] latch;
    wire logic [21:0] ptr;
    pmta_resume_type act;
    int errors, compares, i;
    // pointer actions from awkward starting points
    logic [21:0] p_base [5] = '{22'h000020, 22'h00001f, 22'h000021, 22'h1fffff, 22'h200000};
    pmta_ptr_act_type p_act [5] = '{PMTA_PTR_KEEP, PMTA_PTR_PRE_INC, PMTA_PTR_POST_DEC,
                                    PMTA_PTR_POST_INC, PMTA_PTR_POST_DEC};
    logic [21:0] p_exp [5] = '{22'h000020, 22'h000020, 22'h000020, 22'h000000, 22'h3fffff};
    logic [7:0] l_exp [3] = '{8'h12, 8'h12, 8'h34};
    // {high priority, high/global enable, low/peripheral enable} and the expected resume
    logic [2:0] r_cfg [5] = '{3'b000, 3'b101, 3'b010, 3'b001, 3'b110};
    pmta_resume_type r_exp [5] = '{PMTA_RES_NEXT, PMTA_RES_NEXT, PMTA_RES_NEXT,
                                   PMTA_RES_LOW_VEC, PMTA_RES_HIGH_VEC};

    pmta_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .op_valid_i(op_valid), .op_write_i(op_write), .op_act_i(op_act),
        .master_clear_program_pin_i(vpp), .src_irq_enable_i(ien), .src_irq_flag_i(iflag),
        .src_irq_high_prio_i(ihigh), .global_high_irq_enable_i(glh),
        .peripheral_low_irq_enable_i(pl), .core_halt_o(halt), .resume_valid_o(rvalid),
        .resume_act_o(ract), .table_byte_latch_o(latch), .program_pointer_o(ptr));

    pmta_core_model i_core (.clk_i(clk_i), .core_halt_i(halt), .resume_valid_i(rvalid),
        .resume_act_i(ract), .op_valid_o(op_valid), .op_write_o(op_write), .op_act_o(op_act),
        .irq_en_o(ien), .irq_flag_o(iflag), .irq_high_o(ihigh), .glh_o(glh), .pl_o(pl));

    always #2 clk_i = ~clk_i;

    task automatic results();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // single word transfer; the master waits for hready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        do @(posedge clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // memory byte through a non-modifying table read
    task automatic mrd(input logic [21:0] p, input logic [7:0] exp);
        ahb(1'b1, OFS_POINTER, {10'h000, p});
        i_core.op(1'b0, PMTA_PTR_KEEP);
        rdc(OFS_LATCH, {24'h000000, exp});
    endtask

    initial begin
        {clk_i, hsel, hwrite, vpp, nrst_i} = '0;
        haddr = '0;
        hwdata = '0;
        htrans = 2'b00;
        hsize = 3'h2;
        errors = 0;
        compares = 0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdc(OFS_POINTER, 32'h0);
        rdc(OFS_LATCH, 32'h0);
        rdc(OFS_RESET_CTRL, 32'h0);
        rdc(8'h10, 32'h0);
        // enable bit clear: the odd write must neither halt nor program
        ahb(1'b1, OFS_LATCH, 32'h5a);
        ahb(1'b1, OFS_POINTER, 32'h20);
        i_core.op(1'b1, PMTA_PTR_POST_INC);
        i_core.op(1'b1, PMTA_PTR_KEEP);
        @(posedge clk_i);
        chk({31'h0, halt}, 32'h0);
        mrd(22'h20, 8'hff);
        mrd(22'h21, 8'hff);
        // programming order: source quiet, enable bit, voltage, even byte, odd byte
        ahb(1'b1, OFS_RESET_CTRL, 32'h40);
        vpp <= 1'b1;
        ahb(1'b1, OFS_LATCH, 32'h12);
        ahb(1'b1, OFS_POINTER, 32'h20);
        i_core.op(1'b1, PMTA_PTR_POST_INC);
        ahb(1'b1, OFS_LATCH, 32'h34);
        i_core.op(1'b1, PMTA_PTR_KEEP);
        @(posedge clk_i);
        chk({31'h0, halt}, 32'h1);
        rdc(OFS_STATUS, 32'h3);
        // a table op issued while halted is dropped
        i_core.op(1'b0, PMTA_PTR_POST_INC);
        rdc(OFS_POINTER, 32'h21);
        for (i = 0; i < 5; i++) begin
            if (i > 0) begin
                ahb(1'b1, OFS_POINTER, 32'h41 + 2 * i);
                i_core.op(1'b1, PMTA_PTR_KEEP);
            end
            i_core.end_write(r_cfg[i][2], r_cfg[i][1], r_cfg[i][0], held, act);
            chk({31'h0, held}, 32'h1);
            chk({30'h0, act}, {30'h0, r_exp[i]});
            chk({31'h0, halt}, 32'h0);
        end
        // one byte changed: read the even byte, rewrite even then odd
        ahb(1'b1, OFS_POINTER, 32'h42);
        i_core.op(1'b0, PMTA_PTR_KEEP);
        i_core.op(1'b1, PMTA_PTR_POST_INC);
        ahb(1'b1, OFS_LATCH, 32'h56);
        i_core.op(1'b1, PMTA_PTR_KEEP);
        i_core.end_write(1'b0, 1'b0, 1'b0, held, act);
        chk({31'h0, held}, 32'h1);
        mrd(22'h42, 8'h12);
        mrd(22'h43, 8'h56);
        vpp <= 1'b0;
        mrd(22'h20, 8'h12);
        mrd(22'h21, 8'h34);
        for (i = 0; i < 5; i++) begin
            ahb(1'b1, OFS_LATCH, 32'ha5);
            ahb(1'b1, OFS_POINTER, {10'h000, p_base[i]});
            i_core.op(1'b0, p_act[i]);
            rdc(OFS_POINTER, {10'h000, p_exp[i]});
            if (i < 3) begin
                rdc(OFS_LATCH, {24'h000000, l_exp[i]});
            end
        end
        // software cannot clear the enable bit, a reset does
        ahb(1'b1, OFS_RESET_CTRL, 32'h0);
        rdc(OFS_RESET_CTRL, 32'h40);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdc(OFS_RESET_CTRL, 32'h0);
        results();
    end

    // the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        errors++;
        results();
    end
endmodule
`default_nettype wire
